// ===== tcpwm_bridge_model.sv
// Far side model: hall sensor pattern, capture pins and external gates.
// Assumes the bench drives hall_en and calls cap_edge right after a clock edge.
`timescale 1ns/1ps

module tcpwm_bridge_model
(
	// Clock.
	input  wire       clk,
	// Control from the bench.
	input  wire       hall_en,
	// Sensor and pin side.
	output reg  [2:0] hall_in,
	output reg  [2:0] cap_in,
	output wire [5:0] ext_in
);
	reg [2:0] step_r;

	// Gates held open, so gating faults would go unseen here.
	assign ext_in = 6'h3F;

	initial
	begin
		hall_in = 3'h1;
		cap_in = 3'h0;
		step_r = 3'h0;
	end

	// A slow one-hot rotation keeps every pattern a legal sensor state.
	always @(posedge clk)
		if (hall_en)
		begin
			step_r <= step_r + 3'h1;
			if (step_r == 3'h7)
				hall_in <= {hall_in[1:0], hall_in[2]};
		end

	task cap_edge(input integer ch);
		begin
			@(posedge clk);
			cap_in[ch] <= 1'b1;
			repeat (4) @(posedge clk);
			cap_in[ch] <= 1'b0;
		end
	endtask
endmodule // tcpwm_bridge_model

// ===== tcpwm_prescaler.v
// Rate divider giving one-cycle count enables from the full clock down to clock over 128.
// Assumes a synchronous run input and a three bit rate select.
`timescale 1ns/1ps

module tcpwm_prescaler
(
	// Clock and reset.
	input  wire       clk,
	input  wire       reset,
	// Control.
	input  wire       run,
	input  wire [2:0] rate_sel,
	// Enable out.
	output reg        tick_r
);

	reg  [6:0] div_r;
	wire [6:0] div_nxt;
	wire [6:0] lim;

	assign lim     = (7'h01 << rate_sel) - 7'h01;
	assign div_nxt = (div_r >= lim) ? 7'h00 : div_r + 7'h01;

	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			div_r  <= 7'h00;
			tick_r <= 1'b0;
		end
		else if (!run)
		begin
			div_r  <= 7'h00;
			tick_r <= 1'b0;
		end
		else
		begin
			div_r  <= div_nxt;
			tick_r <= (div_r >= lim);
		end
	end

endmodule // tcpwm_prescaler

// ===== tcpwm_properties.sv
// Port checker for the three channel PWM and capture unit.
// Assumes the one wait state bus answer and registered outputs of the top module.
`timescale 1ns/1ps

module tcpwm_properties
(
	// Clock and reset.
	input wire        clk,
	input wire        reset,
	// Bus.
	input wire        avs_read,
	input wire        avs_write,
	input wire [31:0] avs_readdata,
	input wire        avs_waitrequest,
	// Outputs.
	input wire [2:0]  primary_out_r,
	input wire [2:0]  channel_secondary_output_r,
	input wire        aux_out_r,
	input wire        irq_r
);
	// ****************************************************************
	// Port relations
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	wire req = avs_read || avs_write;

	wait_first_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("wait low too long");
	wait_idle_a: assert property (!req |=> avs_waitrequest)
		else $error("wait low with no request");
	wait_cause_a: assert property (!avs_waitrequest |-> $past(req))
		else $error("answer with no cause");
	out_reset_a: assert property ($fell(reset) |->
		(primary_out_r == 3'h0 && channel_secondary_output_r == 3'h0 && !aux_out_r)[*3])
		else $error("outputs not passive after reset");
	irq_reset_a: assert property ($fell(reset) |-> !irq_r ##1 !irq_r ##1 !irq_r)
		else $error("interrupt after reset");
	irq_clear_a: assert property ($fell(irq_r) |->
		$past(avs_write && !avs_waitrequest) || $past(avs_write && !avs_waitrequest, 2))
		else $error("interrupt dropped with no write");
	rdata_hold_a: assert property ($changed(avs_readdata) |-> $past(avs_read))
		else $error("read data changed with no read");

	cover property ($rose(irq_r));
	cover property ($rose(primary_out_r[0]));
	cover property (avs_write && !avs_waitrequest);
endmodule // tcpwm_properties

bind tcpwm_top tcpwm_properties chk_u
(
	.clk                        (clk),
	.reset                      (reset),
	.avs_read                   (avs_read),
	.avs_write                  (avs_write),
	.avs_readdata               (avs_readdata),
	.avs_waitrequest            (avs_waitrequest),
	.primary_out_r              (primary_out_r),
	.channel_secondary_output_r (channel_secondary_output_r),
	.aux_out_r                  (aux_out_r),
	.irq_r                      (irq_r)
);

// ===== tcpwm_regs.vh
// Register map, field positions and reset values of the three channel PWM and capture unit.
// Assumes inclusion by bare name from the design files of this block.
`ifndef TCPWM_REGS_VH
`define TCPWM_REGS_VH

// ****************************************************************
// Register offsets, byte addresses of aligned words
// ****************************************************************
`define TCPWM_CTRL_OFS      6'h00
`define TCPWM_MAIN_PER_OFS  6'h04
`define TCPWM_OFFSET_OFS    6'h08
`define TCPWM_AUX_PER_OFS   6'h0C
`define TCPWM_CMP0_OFS      6'h10
`define TCPWM_CMP1_OFS      6'h14
`define TCPWM_CMP2_OFS      6'h18
`define TCPWM_AUX_CMP_OFS   6'h1C
`define TCPWM_PASSIVE_OFS   6'h20
`define TCPWM_OUTCTL_OFS    6'h24
`define TCPWM_STATUS_OFS    6'h28
`define TCPWM_MASK_OFS      6'h2C
`define TCPWM_MAIN_CNT_OFS  6'h30
`define TCPWM_AUX_CNT_OFS   6'h34
`define TCPWM_CAP0_OFS      6'h38
`define TCPWM_CAP1_OFS      6'h3C
`define TCPWM_CAP2_OFS      6'h40

// ****************************************************************
// Control register fields
// ****************************************************************
`define TCPWM_CTRL_MAIN_RUN   0
`define TCPWM_CTRL_AUX_RUN    1
`define TCPWM_CTRL_CENTER     2
`define TCPWM_CTRL_MPRE_LO    4
`define TCPWM_CTRL_MPRE_HI    6
`define TCPWM_CTRL_APRE_LO    8
`define TCPWM_CTRL_APRE_HI    10
`define TCPWM_CTRL_CAP_LO     12
`define TCPWM_CTRL_CAP_HI     14
`define TCPWM_CTRL_RISE       16
`define TCPWM_CTRL_FALL       17
`define TCPWM_CTRL_W          18

// ****************************************************************
// Output control fields
// ****************************************************************
`define TCPWM_OC_MOD_LO   0
`define TCPWM_OC_MOD_HI   5
`define TCPWM_OC_EXT_LO   6
`define TCPWM_OC_EXT_HI   11
`define TCPWM_OC_AUX_INV  12
`define TCPWM_OC_AUX_EN   13
`define TCPWM_OC_BLOCK    14
`define TCPWM_OC_HALL     15
`define TCPWM_OC_W        16

// ****************************************************************
// Status bits: 0..2 capture, 3 main period, 4 aux period, 5 hall change
// ****************************************************************
`define TCPWM_ST_MPER   3
`define TCPWM_ST_APER   4
`define TCPWM_ST_HALL   5
`define TCPWM_ST_W      6

`define TCPWM_ZERO16    16'h0000
`define TCPWM_ZERO10    10'h000
`define TCPWM_ONE16     16'h0001
`define TCPWM_ONE10     10'h001

`endif

// ===== tcpwm_tb_top.sv
// Self-checking bench of the PWM and capture unit.
// Assumes the register map header and a bus answer within a few cycles.
`timescale 1ns/1ps
`include "tcpwm_regs.vh"

module tcpwm_tb_top;
	reg         clk;
	reg         reset;
	reg  [5:0]  avs_address;
	reg         avs_read;
	reg         avs_write;
	reg  [31:0] avs_writedata;
	wire [31:0] avs_readdata;
	wire        avs_waitrequest;
	wire [2:0]  cap_in;
	wire [2:0]  hall_in;
	wire [5:0]  ext_in;
	wire [2:0]  pri_out;
	wire [2:0]  sec_out;
	wire        aux_out;
	wire        irq;
	wire [6:0]  outv = {aux_out, sec_out, pri_out};
	reg         hall_en;
	reg  [31:0] rv;
	reg  [31:0] cv;
	integer     c;
	integer     error_cnt;
	integer     samples_checked;

	tcpwm_top dut_u
	(
		.clk                        (clk),
		.reset                      (reset),
		.avs_address                (avs_address),
		.avs_read                   (avs_read),
		.avs_write                  (avs_write),
		.avs_writedata              (avs_writedata),
		.avs_byteenable             (4'hF),
		.avs_readdata               (avs_readdata),
		.avs_waitrequest            (avs_waitrequest),
		.cap_in                     (cap_in),
		.ext_in                     (ext_in),
		.hall_in                    (hall_in),
		.primary_out_r              (pri_out),
		.channel_secondary_output_r (sec_out),
		.aux_out_r                  (aux_out),
		.irq_r                      (irq)
	);

	tcpwm_bridge_model part_u
	(
		.clk     (clk),
		.hall_en (hall_en),
		.hall_in (hall_in),
		.cap_in  (cap_in),
		.ext_in  (ext_in)
	);

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task final_report;
		begin
			$display("errors %0d checks %0d", error_cnt, samples_checked);
			if (error_cnt == 0 && samples_checked > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask

	task bus(input w, input [5:0] a, input [31:0] d);
		integer i;
		begin
			i = 0;
			avs_address <= a;
			avs_writedata <= d;
			avs_write <= w;
			avs_read <= !w;
			@(posedge clk);
			while (avs_waitrequest !== 1'b0 && i < 20)
			begin
				@(posedge clk);
				i = i + 1;
			end
			rv = avs_readdata;
			if (i == 20)
			begin
				error_cnt = error_cnt + 1;
				$display("mismatch at %0t: bus answer timed out", $time);
				final_report;
			end
			avs_write <= 1'b0;
			avs_read <= 1'b0;
			@(posedge clk);
		end
	endtask

	task chk(input [31:0] got, input [31:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (got !== exp)
			begin
				error_cnt = error_cnt + 1;
				$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask

	// Whole periods are counted, so the phase of the window does not matter.
	task ones(input integer b, input integer n);
		integer k;
		begin
			c = 0;
			for (k = 0; k < n; k = k + 1)
			begin
				@(posedge clk);
				c = c + outv[b];
			end
		end
	endtask

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial
	begin
		repeat (60000) @(posedge clk);
		error_cnt = error_cnt + 1;
		final_report;
	end

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial
	begin
		reset = 1'b1;
		avs_address = 6'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		hall_en = 1'b0;
		error_cnt = 0;
		samples_checked = 0;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		bus(0, `TCPWM_CTRL_OFS, 0);
		chk(rv, 32'h0);
		bus(0, `TCPWM_MAIN_CNT_OFS, 0);
		chk(rv, 32'h0);
		chk(outv, 32'h0);
		bus(0, `TCPWM_STATUS_OFS, 0);
		chk(rv, 32'h0);
		bus(0, 6'h02, 0);
		bus(1, `TCPWM_PASSIVE_OFS, 32'h7F);
		repeat (2) @(posedge clk);
		chk(outv, 32'h7F);
		bus(1, `TCPWM_PASSIVE_OFS, 32'h05);
		repeat (2) @(posedge clk);
		chk(outv, 32'h05);
		bus(1, `TCPWM_PASSIVE_OFS, 32'h0);
		bus(1, `TCPWM_MAIN_PER_OFS, 32'h9);
		bus(1, `TCPWM_CMP0_OFS, 32'h4);
		bus(1, `TCPWM_OFFSET_OFS, 32'h2);
		bus(1, `TCPWM_MASK_OFS, 32'h8);
		bus(1, `TCPWM_CTRL_OFS, 32'h1);
		repeat (30) @(posedge clk);
		ones(0, 100);
		chk(c, 60);
		ones(3, 100);
		chk(c, 80);
		ones(1, 100);
		chk(c, 100);
		chk({31'h0, irq}, 32'h1);
		bus(0, `TCPWM_STATUS_OFS, 0);
		chk(rv & 32'h8, 32'h8);
		bus(1, `TCPWM_MASK_OFS, 32'h0);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		bus(1, `TCPWM_CTRL_OFS, 32'h71);
		repeat (1300) @(posedge clk);
		ones(0, 2560);
		chk(c, 1536);
		bus(1, `TCPWM_MAIN_PER_OFS, 32'hA);
		bus(1, `TCPWM_CMP0_OFS, 32'h5);
		bus(1, `TCPWM_AUX_PER_OFS, 32'h9);
		bus(1, `TCPWM_AUX_CMP_OFS, 32'h3);
		bus(1, `TCPWM_OUTCTL_OFS, 32'h2000);
		bus(1, `TCPWM_CTRL_OFS, 32'h7);
		repeat (60) @(posedge clk);
		ones(0, 200);
		chk(c, 100);
		ones(3, 200);
		chk(c, 140);
		ones(6, 100);
		chk(c, 70);
		bus(1, `TCPWM_CTRL_OFS, 32'h11000);
		bus(0, `TCPWM_MAIN_CNT_OFS, 0);
		cv = rv;
		part_u.cap_edge(0);
		repeat (5) @(posedge clk);
		bus(0, `TCPWM_CAP0_OFS, 0);
		chk(rv, cv);
		bus(1, `TCPWM_STATUS_OFS, 32'h3F);
		bus(0, `TCPWM_STATUS_OFS, 0);
		chk(rv, 32'h0);
		hall_en <= 1'b1;
		repeat (40) @(posedge clk);
		bus(0, `TCPWM_STATUS_OFS, 0);
		chk(rv & 32'h20, 32'h20);
		final_report;
	end
endmodule // tcpwm_tb_top

// ===== tcpwm_top.v
// Three channel PWM and capture unit with a main 16-bit and an auxiliary 10-bit timer.
// Assumes an Avalon-MM master, pins synchronous to clk, and a prescaler module.
`timescale 1ns/1ps
`include "tcpwm_regs.vh"

// Summary of operation
// - Three 16-bit capture/compare channels on main timer, one 10-bit compare on aux.
// - Each 16-bit channel drives primary and secondary outputs, secondary edges moved by the edge offset.
// - Aux channel drives its own PWM output and can modulate channel outputs.
// - Aux channel is clocked by aux timer, drives the aux line and can gate the six channel outputs.
// - Both timers free-run at rates from clock down to clock over 128.
// - Edge aligned: count up, clear at period, outputs go passive then.
// - Edge aligned mode exists on both timers.
// - Center aligned: main timer counts up to period, then down, symmetric.
// - Center aligned: up match makes output active, down match makes passive.
// - Only the main timer supports center aligned counting.
// - Secondary outputs compare timer plus edge offset against compare value.
// - Main timer optional edge delay; aux timer edge aligned, no delay.
// - Capture copies main timer into channel capture register on programmed pin edge.
// - Block commutation pattern steered by main timer or sampled hall inputs.
// - Outputs combine with aux channel or external signals without CPU.
// - Edge aligned match sets output active; rollover returns it passive.
// - Passive level of every output is selectable per output in a register.
module tcpwm_top
#(
	parameter MW = 16,
	parameter AW = 10
)
(
	// Clock and reset.
	input  wire        clk,
	input  wire        reset,
	// Avalon-MM slave.
	input  wire [5:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	// Capture pins and external gating signals.
	input  wire [2:0]  cap_in,
	input  wire [5:0]  ext_in,
	input  wire [2:0]  hall_in,
	// Outputs.
	output reg  [2:0]  primary_out_r,
	output reg  [2:0]  channel_secondary_output_r,
	output reg         aux_out_r,
	output reg         irq_r
);

	// ****************************************************************
	// Registers
	// ****************************************************************
	reg  [`TCPWM_CTRL_W-1:0] ctrl_r;
	reg  [MW-1:0] main_timer_period_value_r;
	reg  [MW-1:0] edge_offset_value_r;
	reg  [AW-1:0] aux_period_r;
	reg  [MW-1:0] cmp_r [0:2];
	reg  [AW-1:0] aux_cmp_r;
	reg  [6:0]    passive_level_select_r;
	reg  [`TCPWM_OC_W-1:0] outctl_r;
	reg  [`TCPWM_ST_W-1:0] status_r;
	reg  [`TCPWM_ST_W-1:0] mask_r;
	reg  [MW-1:0] cap_r [0:2];
	reg  [MW-1:0] main_pwm_timer_r;
	reg  [AW-1:0] aux_pwm_timer_r;
	reg           down_r;
	reg  [2:0]    pri_act_r;
	reg  [2:0]    sec_act_r;
	reg           aux_act_r;
	reg  [2:0]    cap_d_r;
	reg  [2:0]    hall_d_r;
	reg           ack_r;
	reg           pins_ok_r;

	wire main_tick;
	wire aux_tick;
	wire center = ctrl_r[`TCPWM_CTRL_CENTER];

	// ****************************************************************
	// Byte lane merge
	// ****************************************************************
	function [31:0] be_merge;
		input [31:0] old;
		input [31:0] wd;
		input [3:0]  be;
		integer k;
		begin
			be_merge = old;
			for (k = 0; k < 4; k = k + 1)
				if (be[k])
					be_merge[k*8 +: 8] = wd[k*8 +: 8];
		end
	endfunction

	// ****************************************************************
	// Prescalers
	// ****************************************************************
	tcpwm_prescaler u_main_pre
	(
		.clk      (clk),
		.reset    (reset),
		.run      (ctrl_r[`TCPWM_CTRL_MAIN_RUN]),
		.rate_sel (ctrl_r[`TCPWM_CTRL_MPRE_HI:`TCPWM_CTRL_MPRE_LO]),
		.tick_r   (main_tick)
	);

	tcpwm_prescaler u_aux_pre
	(
		.clk      (clk),
		.reset    (reset),
		.run      (ctrl_r[`TCPWM_CTRL_AUX_RUN]),
		.rate_sel (ctrl_r[`TCPWM_CTRL_APRE_HI:`TCPWM_CTRL_APRE_LO]),
		.tick_r   (aux_tick)
	);

	// ****************************************************************
	// Main timer
	// ****************************************************************
	wire main_at_per = (main_pwm_timer_r == main_timer_period_value_r);
	wire main_at_zero = (main_pwm_timer_r == `TCPWM_ZERO16);
	wire main_wrap = main_tick && !center && main_at_per;
	wire main_turn = main_tick && center && !down_r && main_at_per;
	wire main_bottom = main_tick && center && down_r && main_at_zero;
	wire [MW-1:0] main_inc = main_at_per ? `TCPWM_ZERO16 : main_pwm_timer_r + `TCPWM_ONE16;

	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			main_pwm_timer_r <= `TCPWM_ZERO16;
			down_r           <= 1'b0;
		end
		else if (main_tick)
		begin
			if (!center)
			begin
				down_r <= 1'b0;
				main_pwm_timer_r <= main_inc;
			end
			else if (!down_r)
			begin
				if (main_at_per)
				begin
					down_r <= 1'b1;
					main_pwm_timer_r <= main_pwm_timer_r - `TCPWM_ONE16;
				end
				else
					main_pwm_timer_r <= main_pwm_timer_r + `TCPWM_ONE16;
			end
			else if (main_at_zero)
			begin
				down_r <= 1'b0;
				main_pwm_timer_r <= `TCPWM_ONE16;
			end
			else
				main_pwm_timer_r <= main_pwm_timer_r - `TCPWM_ONE16;
		end
	end

	// ****************************************************************
	// Auxiliary timer, edge aligned only
	// ****************************************************************
	wire aux_wrap = aux_tick && (aux_pwm_timer_r == aux_period_r);
	wire [AW-1:0] aux_inc = (aux_pwm_timer_r == aux_period_r) ? `TCPWM_ZERO10
		: aux_pwm_timer_r + `TCPWM_ONE10;

	always @(posedge clk or posedge reset)
	begin
		if (reset)
			aux_pwm_timer_r <= `TCPWM_ZERO10;
		else if (aux_tick)
			aux_pwm_timer_r <= aux_inc;
	end

	// The aux channel has no offset path at all, so it can never gain a delayed edge.
	always @(posedge clk or posedge reset)
	begin
		if (reset)
			aux_act_r <= 1'b0;
		else if (aux_tick && aux_inc == aux_cmp_r)
			aux_act_r <= 1'b1;
		else if (aux_wrap)
			aux_act_r <= 1'b0;
	end

	// ****************************************************************
	// Channel compare and capture
	// ****************************************************************
	wire [MW-1:0] main_ref = center ? main_pwm_timer_r : main_inc;
	wire [MW-1:0] shifted = main_ref + edge_offset_value_r;
	wire [2:0] cap_rise = {3{pins_ok_r}} & cap_in & ~cap_d_r;
	wire [2:0] cap_fall = {3{pins_ok_r}} & ~cap_in & cap_d_r;
	wire [2:0] cap_ev;

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1)
		begin : g_ch
			wire is_cap = ctrl_r[`TCPWM_CTRL_CAP_LO + g];
			wire pm = main_tick && (main_ref == cmp_r[g]);
			wire sm = main_tick && (shifted == cmp_r[g]);
			assign cap_ev[g] = is_cap && ((ctrl_r[`TCPWM_CTRL_RISE] && cap_rise[g]) ||
				(ctrl_r[`TCPWM_CTRL_FALL] && cap_fall[g]));

			always @(posedge clk or posedge reset)
			begin
				if (reset)
				begin
					pri_act_r[g] <= 1'b0;
					sec_act_r[g] <= 1'b0;
					cap_r[g]     <= `TCPWM_ZERO16;
				end
				else
				begin
					if (cap_ev[g])
						cap_r[g] <= main_pwm_timer_r;
					if (is_cap)
					begin
						pri_act_r[g] <= 1'b0;
						sec_act_r[g] <= 1'b0;
					end
					else
					begin
						// A match on the wrap beats the clear, so compare zero gives full duty.
						if (pm)
							pri_act_r[g] <= center ? !down_r : 1'b1;
						else if (main_wrap)
							pri_act_r[g] <= 1'b0;
						if (sm)
							sec_act_r[g] <= center ? !down_r : 1'b1;
						else if (main_wrap)
							sec_act_r[g] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Output control and passive levels
	// ****************************************************************
	wire aux_mod = aux_act_r ^ outctl_r[`TCPWM_OC_AUX_INV];
	wire [5:0] raw = {sec_act_r, pri_act_r};
	wire [5:0] hall_pat = {hall_d_r, hall_d_r};
	wire [5:0] blk_pat = outctl_r[`TCPWM_OC_HALL] ? hall_pat : {pri_act_r, pri_act_r};
	wire [5:0] base = outctl_r[`TCPWM_OC_BLOCK] ? (raw & blk_pat) : raw;
	wire [5:0] gate_aux = outctl_r[`TCPWM_OC_MOD_HI:`TCPWM_OC_MOD_LO];
	wire [5:0] gate_ext = outctl_r[`TCPWM_OC_EXT_HI:`TCPWM_OC_EXT_LO];
	wire [5:0] act = base & (~gate_aux | {6{aux_mod}}) & (~gate_ext | ext_in);

	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			primary_out_r              <= 3'h0;
			channel_secondary_output_r <= 3'h0;
			aux_out_r                  <= 1'b0;
			cap_d_r                    <= 3'h0;
			hall_d_r                   <= 3'h0;
			pins_ok_r                  <= 1'b0;
		end
		else
		begin
			primary_out_r              <= act[2:0] ^ passive_level_select_r[2:0];
			channel_secondary_output_r <= act[5:3] ^ passive_level_select_r[5:3];
			aux_out_r <= (aux_act_r & outctl_r[`TCPWM_OC_AUX_EN]) ^ passive_level_select_r[6];
			cap_d_r                    <= cap_in;
			hall_d_r                   <= hall_in;
			pins_ok_r                  <= 1'b1;
		end
	end

	// ****************************************************************
	// Register bus and interrupts
	// ****************************************************************
	wire       wr = avs_write && !avs_waitrequest;
	wire [5:0] ev = {pins_ok_r && (hall_in != hall_d_r), aux_wrap, main_wrap | main_bottom, cap_ev};
	wire [31:0] st_w1c = be_merge(32'h0000_0000, avs_writedata, avs_byteenable);
	wire [31:0] ctrl_mrg = be_merge({14'h0000, ctrl_r}, avs_writedata, avs_byteenable);
	reg  [31:0] rd_nxt;

	always @*
	begin
		case (avs_address)
			`TCPWM_CTRL_OFS:     rd_nxt = {14'h0000, ctrl_r};
			`TCPWM_MAIN_PER_OFS: rd_nxt = {16'h0000, main_timer_period_value_r};
			`TCPWM_OFFSET_OFS:   rd_nxt = {16'h0000, edge_offset_value_r};
			`TCPWM_AUX_PER_OFS:  rd_nxt = {22'h000000, aux_period_r};
			`TCPWM_CMP0_OFS:     rd_nxt = {16'h0000, cmp_r[0]};
			`TCPWM_CMP1_OFS:     rd_nxt = {16'h0000, cmp_r[1]};
			`TCPWM_CMP2_OFS:     rd_nxt = {16'h0000, cmp_r[2]};
			`TCPWM_AUX_CMP_OFS:  rd_nxt = {22'h000000, aux_cmp_r};
			`TCPWM_PASSIVE_OFS:  rd_nxt = {25'h0000000, passive_level_select_r};
			`TCPWM_OUTCTL_OFS:   rd_nxt = {16'h0000, outctl_r};
			`TCPWM_STATUS_OFS:   rd_nxt = {26'h0000000, status_r};
			`TCPWM_MASK_OFS:     rd_nxt = {26'h0000000, mask_r};
			`TCPWM_MAIN_CNT_OFS: rd_nxt = {16'h0000, main_pwm_timer_r};
			`TCPWM_AUX_CNT_OFS:  rd_nxt = {22'h000000, aux_pwm_timer_r};
			`TCPWM_CAP0_OFS:     rd_nxt = {16'h0000, cap_r[0]};
			`TCPWM_CAP1_OFS:     rd_nxt = {16'h0000, cap_r[1]};
			`TCPWM_CAP2_OFS:     rd_nxt = {16'h0000, cap_r[2]};
			default:             rd_nxt = 32'h0000_0000;
		endcase
	end

	// One wait state per access keeps read data registered at the sampling edge.
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			ack_r           <= 1'b0;
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
			irq_r           <= 1'b0;
			status_r        <= 6'h00;
			mask_r          <= 6'h00;
			ctrl_r          <= 18'h00000;
			main_timer_period_value_r <= `TCPWM_ZERO16;
			edge_offset_value_r <= `TCPWM_ZERO16;
			aux_period_r    <= `TCPWM_ZERO10;
			cmp_r[0]        <= `TCPWM_ZERO16;
			cmp_r[1]        <= `TCPWM_ZERO16;
			cmp_r[2]        <= `TCPWM_ZERO16;
			aux_cmp_r       <= `TCPWM_ZERO10;
			passive_level_select_r <= 7'h00;
			outctl_r        <= 16'h0000;
		end
		else
		begin
			ack_r           <= (avs_read || avs_write) && !ack_r;
			avs_waitrequest <= !((avs_read || avs_write) && !ack_r);
			if (avs_read && !ack_r)
				avs_readdata <= rd_nxt;
			// Set wins over a simultaneous write-one clear.
			if (wr && avs_address == `TCPWM_STATUS_OFS)
				status_r <= (status_r & ~st_w1c[5:0]) | ev;
			else
				status_r <= status_r | ev;
			irq_r <= |(status_r & mask_r);
			if (wr)
			begin
				case (avs_address)
				`TCPWM_CTRL_OFS:
					ctrl_r <= ctrl_mrg[`TCPWM_CTRL_W-1:0];
				`TCPWM_MAIN_PER_OFS:
					main_timer_period_value_r <= avs_writedata[15:0];
				`TCPWM_OFFSET_OFS:
					edge_offset_value_r <= avs_writedata[15:0];
				`TCPWM_AUX_PER_OFS:  aux_period_r <= avs_writedata[9:0];
				`TCPWM_CMP0_OFS:     cmp_r[0] <= avs_writedata[15:0];
				`TCPWM_CMP1_OFS:     cmp_r[1] <= avs_writedata[15:0];
				`TCPWM_CMP2_OFS:     cmp_r[2] <= avs_writedata[15:0];
				`TCPWM_AUX_CMP_OFS:  aux_cmp_r <= avs_writedata[9:0];
				`TCPWM_PASSIVE_OFS:  passive_level_select_r <= avs_writedata[6:0];
				`TCPWM_OUTCTL_OFS:   outctl_r <= avs_writedata[15:0];
				`TCPWM_MASK_OFS:     mask_r <= avs_writedata[5:0];
				default:             ;
				endcase
			end
		end
	end

endmodule // tcpwm_top
